// File: stbc_pkg.sv
// Purpose: Shared constants for the serial transmitter with break and collision logic
// Assumes: 8-bit register port, 16x baud tick from the fractional divider
// Notes: Offsets, field positions, reset values and tick counts live here
//
// Overview of operation
// - Eight or nine bit characters, ninth from data high
// - Start zero at LSB, stop one at MSB
// - Handoff sets empty flag, enable raises request
// - Handoff at nine sixteenths into stop bit
// - Empty flag resets set; data write clears it
// - Zero divisor stops baud; high waits for low
// - Enable rise queues preamble of 10/11 ones
// - Line idles high when no frame shifts, low with tx_pol set
// - Disable mid-frame finishes frame, then idles
// - Enable toggle mid-frame queues one idle character
// - Disabled and finished transmitter releases the pin
// - Odd or even parity in the MSB
// - Break repeats zeros, ends with a one
// - Break without detection sets framing, full, clears data
// - Break with detection sets only break flag
// - Mid-character break transfers partial byte first
// - Bit error modes compare line at sample point
// - Collision drives recessive, aborts, drops buffer
// - Collision sets flags, blocks until cleared
// - Bit error mode off clears bit error flag
// - Bit time is sixteen baud ticks

package stbc_pkg;

  // Register offsets
  localparam logic [2:0] ADDR_BAUD_HIGH = 3'h0;
  localparam logic [2:0] ADDR_BAUD_LOW = 3'h1;
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h2;
  localparam logic [2:0] ADDR_CTRL_TWO = 3'h3;
  localparam logic [2:0] ADDR_STAT_ONE = 3'h4;
  localparam logic [2:0] ADDR_STAT_TWO = 3'h5;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h6;
  localparam logic [2:0] ADDR_DATA_LOW = 3'h7;

  // Control register one fields
  localparam int CR1_PAR_ODD = 0;
  localparam int CR1_PAR_EN = 1;
  localparam int CR1_BRK_DET_EN = 2;
  localparam int CR1_NINE_BIT = 4;
  localparam int CR1_BERR_LO = 5;
  localparam int CR1_BERR_HI = 6;

  // Control register two fields
  localparam int CR2_SEND_BRK = 0;
  localparam int CR2_TX_POL = 1;
  localparam int CR2_RX_POL = 2;
  localparam int CR2_TX_EN = 3;
  localparam int CR2_TX_IRQ_EN = 7;

  // Status register fields
  localparam int SR1_RX_ACTIVE = 0;
  localparam int SR1_FRAME_ERR = 1;
  localparam int SR1_PAR_ERR = 2;
  localparam int SR1_RX_FULL = 5;
  localparam int SR1_TX_DONE = 6;
  localparam int SR1_TX_EMPTY = 7;
  localparam int SR2_BIT_ERR = 6;
  localparam int SR2_BRK_DET = 7;

  // Data register high fields
  localparam int DRH_TX_NINTH = 6;
  localparam int DRH_RX_NINTH = 7;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic TX_EMPTY_RST = 1'b1;

  // Timing counts in baud ticks, character and zero-run lengths in bits
  localparam logic [16:0] RT_STEP = 17'h0_0010;
  localparam logic [3:0] RT_LAST_TICK = 4'hF;
  localparam logic [3:0] TX_LOAD_TICK = 4'h8;
  localparam logic [3:0] RX_SAMPLE_TICK = 4'h7;
  localparam logic [3:0] BERR_SAMPLE_A = 4'h9;
  localparam logic [3:0] BERR_SAMPLE_B = 4'hC;
  localparam logic [3:0] CHAR_LEN_EIGHT = 4'hA;
  localparam logic [3:0] CHAR_LEN_NINE = 4'hB;
  localparam logic [3:0] ZERO_CNT_MAX = 4'hF;

  // Bit error modes that enable checking
  localparam logic [1:0] BERR_MODE_A = 2'h1;
  localparam logic [1:0] BERR_MODE_B = 2'h2;

  function automatic logic [3:0] stbc_char_len(input logic nine_bit);
    return nine_bit ? CHAR_LEN_NINE : CHAR_LEN_EIGHT;
  endfunction

  function automatic logic stbc_parity(input logic [8:0] bits, input logic odd);
    return (^bits) ^ odd;
  endfunction

endpackage

// File: stbc_baud_gen.sv
// Purpose: Fractional divider giving the 16x baud tick
// Assumes: Divisor is bus clocks per bit, low four bits fine adjust
// Notes: Nonzero divisors below sixteen tick every cycle
`timescale 1ns/1ps
`default_nettype none

module stbc_baud_gen
  import stbc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Divisor
  input wire logic [15:0] divisor_i,
  // Tick
  output logic rt_tick_o
);

  logic [16:0] acc_reg;
  logic [16:0] acc_sum;
  logic [16:0] eff_div;

  always_comb begin
    acc_sum = acc_reg + RT_STEP;
    eff_div = ({1'b0, divisor_i} < RT_STEP) ? RT_STEP : {1'b0, divisor_i};
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || divisor_i == BAUD_RST) begin
      acc_reg <= 17'h0_0000;
      rt_tick_o <= 1'b0;
    end else if (acc_sum >= eff_div) begin
      acc_reg <= acc_sum - eff_div;
      rt_tick_o <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      rt_tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// File: stbc_rx_sync.sv
// Purpose: Three-stage synchroniser for the receive pin
// Assumes: Pin idles high
// Notes: Output follows once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module stbc_rx_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Line
  input wire logic line_i,
  output logic line_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      line_o <= 1'b1;
    end else begin
      s1_reg <= line_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        line_o <= s3_reg;
      end
    end
  end

endmodule

`default_nettype wire

// File: stbc_top.sv
// Purpose: Serial transmitter with break sending, break detection and collision abort
// Assumes: 10 MHz clock, one-cycle register strobes, read data a cycle later
// Notes: Receiver only frames characters far enough to show break effects
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module stbc_top
  import stbc_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Serial line
  output logic tx_o,
  output logic tx_oe_n_o,
  input wire logic rx_i,
  // Requests
  output logic tx_irq_o
);

  typedef enum logic [1:0] {
    TXS_IDLE = 2'b01,
    TXS_SHIFT = 2'b10
  } stbc_tx_state_e;

  typedef enum logic [2:0] {
    RXS_IDLE = 3'b001,
    RXS_FRAME = 3'b010,
    RXS_LOW = 3'b100
  } stbc_rx_state_e;

  // Registers
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] baud_high_reg;
  logic [15:0] sbr_reg;
  logic [7:0] tx_data_reg;
  logic tx_ninth_bit_reg;
  logic [7:0] rx_data_reg;
  logic rx_ninth_bit_reg;
  logic tx_buffer_empty_reg;
  logic rx_full_reg;
  logic framing_error_reg;
  logic parity_error_reg;
  logic break_detect_reg;
  logic bit_error_reg;

  // Transmit state
  stbc_tx_state_e tx_state_reg;
  logic [3:0] tx_sub_reg;
  logic [3:0] tx_left_reg;
  logic [10:0] tx_sr_reg;
  logic tx_line_reg;
  logic idle_pend_reg;
  logic brk_tail_reg;

  // Receive state
  stbc_rx_state_e rx_state_reg;
  logic [3:0] rx_rt_reg;
  logic [3:0] rx_idx_reg;
  logic [8:0] rx_sr_reg;
  logic [3:0] zero_cnt_reg;

  // Decoded controls
  logic nine_bit;
  logic par_en;
  logic par_odd;
  logic brk_det_en;
  logic [1:0] bit_error_mode;
  logic tx_en;
  logic send_brk;
  logic tx_pol;
  logic rx_pol;
  logic berr_on;
  logic [3:0] char_len;

  // Strobes and events
  logic wr_baud_high;
  logic wr_baud_low;
  logic wr_ctrl_one;
  logic wr_ctrl_two;
  logic wr_stat_two;
  logic wr_data_high;
  logic wr_data_low;
  logic rd_data_low;
  logic tx_en_rise;
  logic rt_tick;
  logic rx_sync;
  logic rx_bit;

  // Transmit selection
  logic take_break;
  logic take_mark;
  logic take_idle;
  logic take_data;
  logic any_load;
  logic load_now;
  logic [10:0] load_vec;
  logic [3:0] load_len;
  logic [8:0] tx_payload;
  logic [3:0] berr_point;
  logic collision;

  // Receive events
  logic rx_sample;
  logic [3:0] zero_inc;
  logic brk_hit;
  logic stop_evt;
  logic rx_xfer;

  always_comb begin
    nine_bit = ctrl_one_reg[CR1_NINE_BIT];
    par_en = ctrl_one_reg[CR1_PAR_EN];
    par_odd = ctrl_one_reg[CR1_PAR_ODD];
    brk_det_en = ctrl_one_reg[CR1_BRK_DET_EN];
    bit_error_mode = ctrl_one_reg[CR1_BERR_HI:CR1_BERR_LO];
    tx_en = ctrl_two_reg[CR2_TX_EN];
    send_brk = ctrl_two_reg[CR2_SEND_BRK];
    tx_pol = ctrl_two_reg[CR2_TX_POL];
    rx_pol = ctrl_two_reg[CR2_RX_POL];
    berr_on = (bit_error_mode == BERR_MODE_A) || (bit_error_mode == BERR_MODE_B);
    char_len = stbc_char_len(nine_bit);
    wr_baud_high = reg_wr_i && (reg_addr_i == ADDR_BAUD_HIGH);
    wr_baud_low = reg_wr_i && (reg_addr_i == ADDR_BAUD_LOW);
    wr_ctrl_one = reg_wr_i && (reg_addr_i == ADDR_CTRL_ONE);
    wr_ctrl_two = reg_wr_i && (reg_addr_i == ADDR_CTRL_TWO);
    wr_stat_two = reg_wr_i && (reg_addr_i == ADDR_STAT_TWO);
    wr_data_high = reg_wr_i && (reg_addr_i == ADDR_DATA_HIGH);
    wr_data_low = reg_wr_i && (reg_addr_i == ADDR_DATA_LOW);
    rd_data_low = reg_rd_i && (reg_addr_i == ADDR_DATA_LOW);
    tx_en_rise = wr_ctrl_two && reg_wdata_i[CR2_TX_EN] && !tx_en;
    rx_bit = rx_sync ^ rx_pol;
  end

  stbc_baud_gen u_baud (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .divisor_i(sbr_reg),
    .rt_tick_o(rt_tick)
  );

  stbc_rx_sync u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .line_i(rx_i),
    .line_o(rx_sync)
  );

  // Configuration registers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_one_reg <= CTRL_ONE_RST;
      ctrl_two_reg <= CTRL_TWO_RST;
      baud_high_reg <= BAUD_RST[15:8];
      sbr_reg <= BAUD_RST;
    end else begin
      if (wr_ctrl_one) begin
        ctrl_one_reg <= reg_wdata_i;
      end
      if (wr_ctrl_two) begin
        ctrl_two_reg <= reg_wdata_i;
      end
      if (wr_baud_high) begin
        baud_high_reg <= reg_wdata_i;
      end
      if (wr_baud_low) begin
        sbr_reg <= {baud_high_reg, reg_wdata_i};
      end
    end
  end

  // Transmit buffer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_data_reg <= 8'h00;
      tx_ninth_bit_reg <= 1'b0;
    end else begin
      if (wr_data_high) begin
        tx_ninth_bit_reg <= reg_wdata_i[DRH_TX_NINTH];
      end
      if (wr_data_low) begin
        tx_data_reg <= reg_wdata_i;
      end
    end
  end

  // Frame building and next-character choice
  always_comb begin
    tx_payload = {tx_ninth_bit_reg, tx_data_reg};
    if (!nine_bit) begin
      tx_payload[8] = 1'b1;
    end
    if (par_en && nine_bit) begin
      tx_payload[8] = stbc_parity({1'b0, tx_data_reg}, par_odd);
    end else if (par_en) begin
      tx_payload[7] = stbc_parity({2'b00, tx_data_reg[6:0]}, par_odd);
    end
    take_break = tx_en && send_brk && !bit_error_reg;
    take_mark = !take_break && brk_tail_reg;
    take_idle = !take_break && !take_mark && tx_en && idle_pend_reg && !bit_error_reg;
    take_data = !take_break && !take_mark && !take_idle && tx_en && !tx_buffer_empty_reg
      && !bit_error_reg;
    any_load = take_break || take_mark || take_idle || take_data;
    load_now = rt_tick && any_load && ((tx_state_reg == TXS_IDLE)
      || ((tx_sub_reg == TX_LOAD_TICK) && (tx_left_reg == 4'h0)));
    load_vec = {11{1'b1}};
    load_len = char_len;
    if (take_break) begin
      load_vec = 11'h000;
    end else if (take_mark) begin
      load_len = 4'h1;
    end else if (take_data) begin
      load_vec = {1'b1, tx_payload, 1'b0};
    end
    berr_point = (bit_error_mode == BERR_MODE_A) ? BERR_SAMPLE_A : BERR_SAMPLE_B;
    collision = berr_on && rt_tick && (tx_state_reg == TXS_SHIFT) && (tx_sub_reg == berr_point)
      && (tx_line_reg != rx_bit);
  end

  // Transmit shifter
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_state_reg <= TXS_IDLE;
      tx_sub_reg <= 4'h0;
      tx_left_reg <= 4'h0;
      tx_sr_reg <= {11{1'b1}};
      tx_line_reg <= 1'b1;
    end else if (collision) begin
      tx_state_reg <= TXS_IDLE;
      tx_sub_reg <= 4'h0;
      tx_left_reg <= 4'h0;
      tx_sr_reg <= {11{1'b1}};
      tx_line_reg <= 1'b1;
    end else if (rt_tick) begin
      unique case (tx_state_reg)
        TXS_IDLE: begin
          if (load_now) begin
            tx_state_reg <= TXS_SHIFT;
            tx_sub_reg <= 4'h0;
            tx_line_reg <= load_vec[0];
            tx_sr_reg <= {1'b1, load_vec[10:1]};
            tx_left_reg <= load_len - 4'h1;
          end
        end
        TXS_SHIFT: begin
          tx_sub_reg <= tx_sub_reg + 4'h1;
          if (load_now) begin
            tx_sr_reg <= load_vec;
            tx_left_reg <= load_len;
          end
          if (tx_sub_reg == RT_LAST_TICK && tx_left_reg != 4'h0) begin
            tx_line_reg <= tx_sr_reg[0];
            tx_sr_reg <= {1'b1, tx_sr_reg[10:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
          end else if (tx_sub_reg == RT_LAST_TICK) begin
            tx_state_reg <= TXS_IDLE;
            tx_line_reg <= 1'b1;
          end
        end
      endcase
    end
  end

  // Transmit flags
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_buffer_empty_reg <= TX_EMPTY_RST;
      idle_pend_reg <= 1'b0;
      brk_tail_reg <= 1'b0;
    end else begin
      if (collision || (load_now && take_data)) begin
        tx_buffer_empty_reg <= 1'b1;
      end else if (wr_data_low) begin
        tx_buffer_empty_reg <= 1'b0;
      end
      if (tx_en_rise) begin
        idle_pend_reg <= 1'b1;
      end else if (collision || (load_now && take_idle)) begin
        idle_pend_reg <= 1'b0;
      end
      if (collision || (load_now && take_mark)) begin
        brk_tail_reg <= 1'b0;
      end else if (load_now && take_break) begin
        brk_tail_reg <= 1'b1;
      end
    end
  end

  // Bit error flag
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      bit_error_reg <= 1'b0;
    end else if (!berr_on) begin
      bit_error_reg <= 1'b0;
    end else if (collision) begin
      bit_error_reg <= 1'b1;
    end else if (wr_stat_two && reg_wdata_i[SR2_BIT_ERR]) begin
      bit_error_reg <= 1'b0;
    end
  end

  // Pin drivers
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tx_o <= 1'b1;
      tx_oe_n_o <= 1'b1;
    end else begin
      tx_o <= tx_line_reg ^ tx_pol;
      tx_oe_n_o <= !(tx_en || (tx_state_reg == TXS_SHIFT));
    end
  end

  assign tx_irq_o = tx_buffer_empty_reg && ctrl_two_reg[CR2_TX_IRQ_EN];

  // Receive events
  always_comb begin
    rx_sample = rt_tick && (rx_rt_reg == RX_SAMPLE_TICK) && (rx_state_reg != RXS_IDLE);
    zero_inc = (zero_cnt_reg == ZERO_CNT_MAX) ? zero_cnt_reg : zero_cnt_reg + 4'h1;
    brk_hit = rx_sample && !rx_bit && (zero_inc == char_len);
    stop_evt = rx_sample && (rx_state_reg == RXS_FRAME) && (rx_idx_reg == char_len - 4'h1);
    rx_xfer = stop_evt && !(brk_det_en && brk_hit);
  end

  // Receive framer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_state_reg <= RXS_IDLE;
      rx_rt_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_sr_reg <= 9'h000;
      zero_cnt_reg <= 4'h0;
    end else if (rt_tick) begin
      rx_rt_reg <= rx_rt_reg + 4'h1;
      if (rx_sample) begin
        zero_cnt_reg <= rx_bit ? 4'h0 : zero_inc;
      end
      unique case (rx_state_reg)
        RXS_IDLE: begin
          if (!rx_bit) begin
            rx_state_reg <= RXS_FRAME;
            rx_rt_reg <= 4'h0;
            rx_idx_reg <= 4'h0;
          end
        end
        RXS_FRAME: begin
          if (rx_sample) begin
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'h0 && rx_bit) begin
              rx_state_reg <= RXS_IDLE;
            end else if (stop_evt) begin
              rx_state_reg <= rx_bit ? RXS_IDLE : RXS_LOW;
            end else if (rx_idx_reg != 4'h0) begin
              rx_sr_reg <= {rx_bit, rx_sr_reg[8:1]};
            end
          end
        end
        RXS_LOW: begin
          if (rx_sample && rx_bit) begin
            rx_state_reg <= RXS_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer and flags
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_data_reg <= 8'h00;
      rx_ninth_bit_reg <= 1'b0;
      rx_full_reg <= 1'b0;
      framing_error_reg <= 1'b0;
      parity_error_reg <= 1'b0;
      break_detect_reg <= 1'b0;
    end else begin
      if (rx_xfer) begin
        rx_full_reg <= 1'b1;
        framing_error_reg <= !rx_bit;
        parity_error_reg <= par_en && stbc_parity(nine_bit ? rx_sr_reg : {1'b0, rx_sr_reg[8:1]},
          par_odd);
        if (brk_hit) begin
          rx_data_reg <= 8'h00;
          rx_ninth_bit_reg <= 1'b0;
        end else if (nine_bit) begin
          rx_data_reg <= rx_sr_reg[7:0];
          rx_ninth_bit_reg <= rx_sr_reg[8];
        end else begin
          rx_data_reg <= rx_sr_reg[8:1];
          rx_ninth_bit_reg <= 1'b0;
        end
      end else if (rd_data_low) begin
        rx_full_reg <= 1'b0;
        framing_error_reg <= 1'b0;
        parity_error_reg <= 1'b0;
      end
      if (brk_hit && brk_det_en) begin
        break_detect_reg <= 1'b1;
      end else if (wr_stat_two && reg_wdata_i[SR2_BRK_DET]) begin
        break_detect_reg <= 1'b0;
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !reg_rd_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= 8'h00;
      unique case (reg_addr_i)
        ADDR_BAUD_HIGH: reg_rdata_o <= sbr_reg[15:8];
        ADDR_BAUD_LOW: reg_rdata_o <= sbr_reg[7:0];
        ADDR_CTRL_ONE: reg_rdata_o <= ctrl_one_reg;
        ADDR_CTRL_TWO: reg_rdata_o <= ctrl_two_reg;
        ADDR_STAT_ONE: begin
          reg_rdata_o[SR1_TX_EMPTY] <= tx_buffer_empty_reg;
          reg_rdata_o[SR1_TX_DONE] <= (tx_state_reg == TXS_IDLE);
          reg_rdata_o[SR1_RX_FULL] <= rx_full_reg;
          reg_rdata_o[SR1_PAR_ERR] <= parity_error_reg;
          reg_rdata_o[SR1_FRAME_ERR] <= framing_error_reg;
          reg_rdata_o[SR1_RX_ACTIVE] <= (rx_state_reg != RXS_IDLE);
        end
        ADDR_STAT_TWO: begin
          reg_rdata_o[SR2_BRK_DET] <= break_detect_reg;
          reg_rdata_o[SR2_BIT_ERR] <= bit_error_reg;
        end
        ADDR_DATA_HIGH: begin
          reg_rdata_o[DRH_RX_NINTH] <= rx_ninth_bit_reg;
          reg_rdata_o[DRH_TX_NINTH] <= tx_ninth_bit_reg;
        end
        ADDR_DATA_LOW: reg_rdata_o <= rx_data_reg;
      endcase
    end
  end

endmodule

`default_nettype wire

// File: stbc_node.sv
// Purpose: Remote node on the serial line
// Assumes: Line pulled up, equal polarities
// Notes: Can pull the line low to collide
`timescale 1ns/1ps
`default_nettype none

module stbc_node (
  // Line from block
  input wire logic tx_i,
  input wire logic tx_oe_n_i,
  // Collision control
  input wire logic pull_lo_i,
  // Line to block
  output logic rx_o
);
  // Wired line, pull-up when released
  assign rx_o = pull_lo_i ? 1'b0 : (tx_oe_n_i ? 1'b1 : tx_i);
endmodule

`default_nettype wire

// File: stbc_top_assertions.sv
// Purpose: Port checks for the transmitter
// Assumes: Divisor 16, polarities zero
// Notes: One bit is sixteen clocks
`timescale 1ns/1ps
`default_nettype none

module stbc_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Serial line
  input wire logic tx_o,
  input wire logic tx_oe_n_o,
  input wire logic rx_i,
  input wire logic tx_irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_rdata_quiet: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data outside slot");
  chk_idle_high: assert property (tx_oe_n_o |-> tx_o)
    else $error("released line not high");
  chk_bit_len: assert property ($fell(tx_o) |=> !tx_o [*8])
    else $error("low bit too short");
  chk_pre_ones: assert property ($fell(tx_oe_n_o) |-> tx_o [*8])
    else $error("no preamble after enable");
  chk_irq_rise: assert property ($rose(tx_irq_o) |-> $past(reg_wr_i) || !tx_oe_n_o)
    else $error("request without handoff");
  chk_irq_fall: assert property ($fell(tx_irq_o) |-> $past(reg_wr_i))
    else $error("empty cleared without write");
  chk_oe_release: assert property ($rose(tx_oe_n_o) |-> tx_o && $past(tx_o))
    else $error("pin released mid frame");
  chk_oe_cause: assert property ($fell(tx_oe_n_o) |->
    $past(reg_wr_i) || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
    else $error("pin driven without enable");

  cov_frame: cover property ($fell(tx_o));
  cov_irq: cover property ($rose(tx_irq_o));
  cov_release: cover property ($rose(tx_oe_n_o));
endmodule

bind stbc_top stbc_chk i_stbc_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_o(tx_o),
  .tx_oe_n_o(tx_oe_n_o), .rx_i(rx_i), .tx_irq_o(tx_irq_o));

`default_nettype wire

// File: stbc_top_tb.sv
// Purpose: Self-checking bench for the transmitter
// Assumes: Divisor 16, loopback partner
// Notes: Reads and frames checked from queues
`timescale 1ns/1ps
`default_nettype none

module stbc_top_tb
  import stbc_pkg::*;
;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic pull_lo = 1'b0;
  logic mon_on = 1'b1;
  logic rd_q = 1'b0;
  logic [15:0] rn;
  logic [15:0] rq[$];
  logic [11:0] fq[$];
  wire logic [7:0] reg_rdata_o;
  wire logic tx_o, tx_oe_n_o, rx_i, tx_irq_o;
  int num_errors = 0;
  int cmp_count = 0;
  int n_fall = 0;
  time t0;

  stbc_top i_stbc_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .tx_o(tx_o),
    .tx_oe_n_o(tx_oe_n_o), .rx_i(rx_i), .tx_irq_o(tx_irq_o));
  stbc_node i_stbc_node (.tx_i(tx_o), .tx_oe_n_i(tx_oe_n_o), .pull_lo_i(pull_lo), .rx_o(rx_i));

  always #50 clock_i = ~clock_i;
  always @(negedge tx_o) n_fall++;

  task automatic tally_and_finish;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    rq.push_back({e, m});
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic wait_hi(input logic irq);
    int i;
    i = 0;
    @(posedge clock_i);
    while ((irq ? tx_irq_o : tx_oe_n_o) !== 1'b1 && i < 600) begin
      @(posedge clock_i);
      i++;
    end
    chk(16'(i < 600), 16'h0001);
  endtask

  function automatic logic [11:0] frm(input logic m, pe, odd, n8, input logic [7:0] d);
    logic hb;
    hb = m ? (pe ? ^d ^ odd : n8) : (pe ? ^d[6:0] ^ odd : d[7]);
    return m ? {2'b11, hb, d, 1'b0} : {3'b011, hb, d[6:0], 1'b0};
  endfunction

  task automatic send2(input logic m, pe, odd, n8);
    logic [7:0] d;
    wr(ADDR_CTRL_ONE, {3'h0, m, 2'h0, pe, odd});
    wr(ADDR_DATA_HIGH, {1'b0, n8, 6'h00});
    wr(ADDR_CTRL_TWO, 8'h88);
    for (int j = 0; j < 2; j++) begin
      d = 8'($urandom);
      fq.push_back(frm(m, pe, odd, n8, d));
      if (j == 1) begin
        wr(ADDR_CTRL_TWO, 8'h80);
        wr(ADDR_CTRL_TWO, 8'h88);
      end
      wr(ADDR_DATA_LOW, d);
      rd(ADDR_STAT_ONE, 8'h00, 8'h80);
      chk({15'h0, tx_irq_o}, 16'h0000);
      wait_hi(1'b1);
      if (j == 1) chk(16'((($time - t0) / 100) > 250), 16'h0001);
      t0 = $time;
    end
    wr(ADDR_CTRL_TWO, 8'h00);
    wait_hi(1'b0);
  endtask

  always @(posedge clock_i) begin
    rd_q <= reg_rd_i;
    if (rd_q) begin
      rn = rq.pop_front();
      chk({8'h00, reg_rdata_o & rn[7:0]}, {8'h00, rn[15:8] & rn[7:0]});
    end
  end

  initial begin : frame_mon
    logic [11:0] e;
    logic [10:0] v;
    forever begin
      @(negedge tx_o iff (mon_on && !tx_oe_n_o));
      e = fq.pop_front();
      v = '1;
      repeat (8) @(posedge clock_i);
      for (int i = 0; i < (e[11] ? 11 : 10); i++) begin
        if (i > 0) repeat (16) @(posedge clock_i);
        v[i] = tx_o;
      end
      chk({5'h00, v}, {5'h00, e[10:0]});
    end
  end

  initial begin
    repeat (30000) @(posedge clock_i);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h96bea230));
    repeat (6) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_STAT_ONE, 8'hC0, 8'hFF);
    rd(ADDR_STAT_TWO, 8'h00, 8'hFF);
    wr(ADDR_CTRL_TWO, 8'h08);
    fq.push_back(frm(1'b0, 1'b0, 1'b0, 1'b0, 8'hA5));
    wr(ADDR_DATA_LOW, 8'hA5);
    repeat (400) @(posedge clock_i);
    chk(16'(n_fall), 16'h0000);
    wr(ADDR_BAUD_HIGH, 8'h00);
    wr(ADDR_BAUD_LOW, 8'h10);
    wr(ADDR_CTRL_TWO, 8'h88);
    wait_hi(1'b1);
    wr(ADDR_CTRL_TWO, 8'h00);
    wait_hi(1'b0);
    for (int k = 0; k < 4; k++) begin
      send2(k[1], k[0], k[1] & k[0], 1'b1);
    end
    mon_on = 1'b0;
    wr(ADDR_CTRL_ONE, 8'h20);
    wr(ADDR_CTRL_TWO, 8'h88);
    wr(ADDR_DATA_LOW, 8'h03);
    @(negedge tx_o);
    repeat (24) @(posedge clock_i);
    pull_lo <= 1'b1;
    repeat (40) @(posedge clock_i);
    chk({15'h0, tx_o}, 16'h0001);
    rd(ADDR_STAT_TWO, 8'h40, 8'h40);
    rd(ADDR_STAT_ONE, 8'hC0, 8'hC0);
    pull_lo <= 1'b0;
    fq.push_back(frm(1'b0, 1'b0, 1'b0, 1'b0, 8'h3C));
    wr(ADDR_DATA_LOW, 8'h3C);
    repeat (300) @(posedge clock_i);
    rd(ADDR_STAT_ONE, 8'h00, 8'h80);
    mon_on = 1'b1;
    wr(ADDR_CTRL_ONE, 8'h00);
    rd(ADDR_STAT_TWO, 8'h00, 8'h40);
    wait_hi(1'b1);
    wr(ADDR_CTRL_TWO, 8'h00);
    wait_hi(1'b0);
    mon_on = 1'b0;
    for (int b = 0; b < 2; b++) begin
      rd(ADDR_DATA_LOW, 8'h00, 8'h00);
      wr(ADDR_CTRL_ONE, {5'h00, b[0], 2'h0});
      wr(ADDR_CTRL_TWO, 8'h08);
      repeat (200) @(posedge clock_i);
      wr(ADDR_CTRL_TWO, 8'h09);
      @(negedge tx_o);
      t0 = $time;
      wr(ADDR_CTRL_TWO, 8'h08);
      @(posedge tx_o);
      chk(16'(($time - t0) / 100), 16'h00A0);
      repeat (15) @(posedge clock_i);
      chk({15'h0, tx_o}, 16'h0001);
      repeat (300) @(posedge clock_i);
      rd(b ? ADDR_STAT_TWO : ADDR_STAT_ONE, b ? 8'h80 : 8'h22, b ? 8'h80 : 8'h22);
      rd(b ? ADDR_STAT_ONE : ADDR_DATA_LOW, 8'h00, b ? 8'h22 : 8'hFF);
    end
    wr(ADDR_STAT_TWO, 8'h80);
    wr(ADDR_DATA_LOW, 8'hFF);
    @(negedge tx_o);
    repeat (48) @(posedge clock_i);
    pull_lo <= 1'b1;
    repeat (300) @(posedge clock_i);
    pull_lo <= 1'b0;
    repeat (40) @(posedge clock_i);
    rd(ADDR_STAT_ONE, 8'h22, 8'h22);
    rd(ADDR_STAT_TWO, 8'h80, 8'h80);
    rd(ADDR_DATA_LOW, 8'h03, 8'hFF);
    repeat (4) @(posedge clock_i);
    chk(16'(fq.size()), 16'h0000);
    tally_and_finish();
  end
endmodule

`default_nettype wire
